// file: rtl/crg_core_regs.sv
`timescale 1ns/1ps
`default_nettype none
module crg_core_regs (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic exec_valid,
	input wire crg_pkg::crg_mode_t exec_mode,
	input wire crg_pkg::crg_op_t exec_op,
	input wire crg_pkg::crg_dst_t exec_dst,
	input wire logic [7:0] exec_operand,
	input wire logic [3:0] exec_flag_upd,
	input wire logic [7:0] mem_rdata,
	input wire logic exec_supervisor,
	input wire crg_pkg::crg_sp_t sp_action,
	input wire logic [7:0] sp_data,
	input wire logic pc_load,
	input wire logic [15:0] pc_target,
	input wire logic pc_advance,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_rd_addr,
	output logic [7:0] accumulator,
	output logic [7:0] index,
	output logic [7:0] stack_top_pointer,
	output logic [7:0] program_counter_high,
	output logic [7:0] program_counter_low,
	output logic [7:0] processor_flags,
	output logic interrupt_master_enable,
	output logic bank_select,
	output logic [7:0] src_addr,
	output logic flags_rd_hit,
	output logic [7:0] flags_rd_data
);
	import crg_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [7:0] acc_r, acc_nxt;
	logic [7:0] idx_r, idx_nxt;
	logic [7:0] sp_r, sp_nxt;
	logic [15:0] pc_r, pc_nxt;
	logic [7:0] flg_r, flg_nxt;
	logic [7:0] saddr_r, saddr_nxt;
	logic hit_r, hit_nxt;
	logic [7:0] frd_r, frd_nxt;

	// ---------------------------------------------------------------
	// operand steering
	// ---------------------------------------------------------------
	logic [7:0] src_a, src_b;
	logic [8:0] res;
	logic op_carry;

	always_comb begin
		// first source is the selected accumulator, index, stack pointer or flags
		src_a = (exec_dst == CRG_DST_IDX) ? idx_r : acc_r;
		if (exec_dst == CRG_DST_SP) begin
			src_a = sp_r;
		end
		if (exec_dst == CRG_DST_FLAGS) begin
			src_a = flg_r;
		end
		if (exec_mode == CRG_MODE_DIRECT) begin
			src_b = mem_rdata;
		end else begin
			src_b = exec_operand;
		end
	end

	// ---------------------------------------------------------------
	// arithmetic and logic
	// ---------------------------------------------------------------
	always_comb begin
		// ninth bit carries out of add and borrow out of subtract
		res = {1'b0, BYTE_ZERO};
		case (exec_op)
			CRG_OP_MOV: res = {1'b0, src_b};
			CRG_OP_ADD: res = {1'b0, src_a} + {1'b0, src_b};
			CRG_OP_SUB: res = {1'b0, src_a} - {1'b0, src_b};
			CRG_OP_AND: res = {1'b0, src_a & src_b};
			CRG_OP_OR: res = {1'b0, src_a | src_b};
			CRG_OP_XOR: res = {1'b0, src_a ^ src_b};
			default: res = {1'b0, src_b};
		endcase
		op_carry = res[8];
	end

	// ---------------------------------------------------------------
	// accumulator
	// ---------------------------------------------------------------
	logic acc_wr;

	always_comb begin
		// only instruction-side ports reach this; no software address decodes it
		acc_wr = exec_valid && (exec_dst == CRG_DST_ACC);
		acc_nxt = acc_r;
		if (acc_wr) begin
			acc_nxt = res[7:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_r <= BYTE_ZERO;
		end else begin
			acc_r <= acc_nxt;
		end
	end

	// ---------------------------------------------------------------
	// index register
	// ---------------------------------------------------------------
	logic idx_wr;

	always_comb begin
		idx_wr = exec_valid && (exec_dst == CRG_DST_IDX);
		idx_nxt = idx_r;
		if (idx_wr) begin
			idx_nxt = res[7:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			idx_r <= BYTE_ZERO;
		end else begin
			idx_r <= idx_nxt;
		end
	end

	// ---------------------------------------------------------------
	// stack pointer
	// ---------------------------------------------------------------
	always_comb begin
		sp_nxt = sp_r;
		if (exec_valid && exec_dst == CRG_DST_SP) begin
			sp_nxt = res[7:0];
		end
		// stack instructions win over a same-cycle result aimed at the pointer
		case (sp_action)
			CRG_SP_PUSH: sp_nxt = sp_r + SP_ONE;
			CRG_SP_CALL: begin
				if (sp_data != BYTE_ZERO) begin
					sp_nxt = sp_r + sp_data;
				end else begin
					sp_nxt = sp_r + SP_ONE;
				end
			end
			CRG_SP_POP, CRG_SP_RET: sp_nxt = sp_r - SP_ONE;
			default: begin
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sp_r <= BYTE_ZERO;
		end else begin
			sp_r <= sp_nxt;
		end
	end

	// ---------------------------------------------------------------
	// program counter
	// ---------------------------------------------------------------
	always_comb begin
		pc_nxt = pc_r;
		// a load wins over any advance in the same cycle
		if (pc_load) begin
			pc_nxt = pc_target;
		end else if (pc_advance && exec_valid) begin
			// any valid instruction, immediate or direct, is two bytes long
			pc_nxt = pc_r + PC_STEP2;
		end else if (pc_advance) begin
			pc_nxt = pc_r + PC_STEP1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_r <= PC_RESET;
		end else begin
			pc_r <= pc_nxt;
		end
	end

	// ---------------------------------------------------------------
	// flags
	// ---------------------------------------------------------------
	always_comb begin
		flg_nxt = flg_r;
		if (exec_valid && exec_dst == CRG_DST_FLAGS) begin
			// software may touch only its own bits; privileged kept
			flg_nxt = (flg_r & ~FLG_USER_MASK) | (res[7:0] & FLG_USER_MASK);
		end else if (exec_valid) begin
			if (exec_flag_upd[FLG_CARRY]) begin
				flg_nxt[FLG_CARRY] = op_carry;
			end
			if (exec_flag_upd[FLG_ZERO]) begin
				flg_nxt[FLG_ZERO] = (res[7:0] == BYTE_ZERO);
			end
		end
		// hardware tracks supervisor state, overriding any user value
		flg_nxt[FLG_SUPER] = exec_supervisor;
		flg_nxt = flg_nxt & FLG_RSVD_MASK;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			flg_r <= FLG_RESET;
		end else begin
			flg_r <= flg_nxt;
		end
	end

	// ---------------------------------------------------------------
	// source address and flags read probe
	// ---------------------------------------------------------------
	always_comb begin
		// direct mode: second byte is the source address
		saddr_nxt = saddr_r;
		if (exec_valid && exec_mode == CRG_MODE_DIRECT) begin
			saddr_nxt = exec_operand;
		end
		// any other address reads as zero, so no other alias exists
		hit_nxt = reg_rd_en && (reg_rd_addr == FLAGS_ADDR);
		frd_nxt = hit_nxt ? flg_r : BYTE_ZERO;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			saddr_r <= BYTE_ZERO;
			hit_r <= 1'b0;
			frd_r <= BYTE_ZERO;
		end else begin
			saddr_r <= saddr_nxt;
			hit_r <= hit_nxt;
			frd_r <= frd_nxt;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign accumulator = acc_r;
	assign index = idx_r;
	assign stack_top_pointer = sp_r;
	assign program_counter_high = pc_r[15:8];
	assign program_counter_low = pc_r[7:0];
	assign processor_flags = flg_r;
	assign interrupt_master_enable = flg_r[FLG_IE];
	assign bank_select = flg_r[FLG_BANK];
	assign src_addr = saddr_r;
	assign flags_rd_hit = hit_r;
	assign flags_rd_data = frd_r;
endmodule
`default_nettype wire

// file: rtl/crg_pkg.sv
package crg_pkg;
	// flags register layout
	localparam int FLG_IE = 0;
	localparam int FLG_ZERO = 1;
	localparam int FLG_CARRY = 2;
	localparam int FLG_SUPER = 3;
	localparam int FLG_BANK = 4;
	localparam logic [7:0] FLG_RESET = 8'h02;
	localparam logic [7:0] FLG_USER_MASK = 8'h17;
	localparam logic [7:0] FLG_RSVD_MASK = 8'h1f;
	localparam logic [7:0] FLAGS_ADDR = 8'hf7;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [15:0] PC_STEP1 = 16'h0001;
	localparam logic [15:0] PC_STEP2 = 16'h0002;
	localparam logic [7:0] SP_ONE = 8'h01;

	// destination of a result
	typedef enum logic [2:0] {
		CRG_DST_NONE,
		CRG_DST_ACC,
		CRG_DST_IDX,
		CRG_DST_SP,
		CRG_DST_FLAGS
	} crg_dst_t;

	// operation on the two sources
	typedef enum logic [2:0] {
		CRG_OP_MOV,
		CRG_OP_ADD,
		CRG_OP_SUB,
		CRG_OP_AND,
		CRG_OP_OR,
		CRG_OP_XOR
	} crg_op_t;

	// operand addressing
	typedef enum logic [1:0] {
		CRG_MODE_IMM,
		CRG_MODE_DIRECT
	} crg_mode_t;

	// stack pointer action
	typedef enum logic [2:0] {
		CRG_SP_HOLD,
		CRG_SP_PUSH,
		CRG_SP_POP,
		CRG_SP_CALL,
		CRG_SP_RET
	} crg_sp_t;
endpackage

// file: testbench/crg_core_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module crg_core_regs_props import crg_pkg::*; (
	input wire logic sys_clk, rst_n, exec_valid, exec_supervisor, pc_load, pc_advance, reg_rd_en,
	input wire crg_mode_t exec_mode,
	input wire crg_op_t exec_op,
	input wire crg_dst_t exec_dst,
	input wire crg_sp_t sp_action,
	input wire logic [7:0] exec_operand, reg_rd_addr, accumulator, stack_top_pointer,
	input wire logic [7:0] program_counter_high, program_counter_low, processor_flags, flags_rd_data,
	input wire logic [15:0] pc_target,
	input wire logic interrupt_master_enable, bank_select, flags_rd_hit
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire logic [15:0] pc = {program_counter_high, program_counter_low};
	ie_mirror_a: assert property (interrupt_master_enable == processor_flags[0])
		else $error("enable bit mismatch");
	bank_mirror_a: assert property (bank_select == processor_flags[4])
		else $error("bank select mismatch");
	rsvd_zero_a: assert property (processor_flags[7:5] == 3'h0)
		else $error("reserved flag bits set");
	super_follow_a: assert property (1 |=> processor_flags[3] == $past(exec_supervisor))
		else $error("privileged bit wrong");
	pc_load_a: assert property (pc_load |=> pc == $past(pc_target))
		else $error("pc load wrong");
	pc_step_a: assert property (pc_advance && !pc_load && !exec_valid |=> pc == $past(pc) + 16'h1)
		else $error("pc step wrong");
	acc_hold_a: assert property (!exec_valid |=> $stable(accumulator))
		else $error("accumulator changed without instruction");
	sp_push_a: assert property (sp_action == CRG_SP_PUSH |=> stack_top_pointer == $past(stack_top_pointer) + 8'h1)
		else $error("push step wrong");
	flags_read_a: assert property (reg_rd_en && reg_rd_addr == FLAGS_ADDR
		|=> flags_rd_hit && flags_rd_data == $past(processor_flags))
		else $error("flags read wrong");
	imm_mov_a: assert property (exec_valid && exec_mode == CRG_MODE_IMM && exec_op == CRG_OP_MOV
		&& exec_dst == CRG_DST_ACC |=> accumulator == $past(exec_operand))
		else $error("immediate move wrong");
	cover property (exec_valid && exec_mode == CRG_MODE_DIRECT);
	cover property (exec_valid && exec_dst == CRG_DST_FLAGS);
	cover property (pc_load ##1 pc_advance);
endmodule
bind crg_core_regs crg_core_regs_props u_props (.*);
`default_nettype wire

// file: testbench/crg_ram_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// data space seen by the decoder
// ----------------------------------------
module crg_ram_model (
	input wire logic [7:0] addr,
	output logic [7:0] rdata
);
	// address-derived contents, so a wrong address shows as a wrong value
	assign rdata = addr ^ 8'h5a;
endmodule
`default_nettype wire

// file: testbench/tb_crg_core_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_crg_core_regs;
	import crg_pkg::*;
	logic sys_clk = 0, rst_n = 0, exec_valid = 0, exec_supervisor = 0;
	logic pc_load = 0, pc_advance = 0, reg_rd_en = 0, flags_rd_hit, interrupt_master_enable, bank_select;
	crg_mode_t exec_mode = CRG_MODE_IMM;
	crg_op_t exec_op = CRG_OP_MOV;
	crg_dst_t exec_dst = CRG_DST_NONE;
	crg_sp_t sp_action = CRG_SP_HOLD;
	logic [3:0] exec_flag_upd = 4'h6;
	logic [7:0] exec_operand = 8'h00, mem_rdata, sp_data = 8'h00, reg_rd_addr = 8'h00;
	logic [7:0] accumulator, index, stack_top_pointer, program_counter_high, program_counter_low;
	logic [7:0] processor_flags, src_addr, flags_rd_data;
	logic [15:0] pc_target = 16'h0000;
	int n_errors = 0, n_tests = 0;
	crg_core_regs dut (.*);
	crg_ram_model ram (.addr(exec_operand), .rdata(mem_rdata));
	initial forever #2.5 sys_clk = ~sys_clk;
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic ex(crg_mode_t m, crg_op_t o, crg_dst_t d, logic [7:0] v);
		@(negedge sys_clk);
		exec_valid = 1'b1;
		exec_mode = m;
		exec_op = o;
		exec_dst = d;
		exec_operand = v;
		@(negedge sys_clk);
		exec_valid = 0;
	endtask
	task automatic stk(crg_sp_t a);
		@(negedge sys_clk);
		sp_action = a;
		@(negedge sys_clk);
		sp_action = CRG_SP_HOLD;
	endtask
	task automatic rd(logic [7:0] a);
		@(negedge sys_clk);
		{reg_rd_en, reg_rd_addr} = {1'b1, a};
		@(negedge sys_clk);
		reg_rd_en = 0;
	endtask
	task automatic final_report();
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(negedge sys_clk);
		rst_n = 1;
		chk(processor_flags, FLG_RESET);
		chk({accumulator, index, stack_top_pointer, program_counter_low}, 0);
		ex(CRG_MODE_IMM, CRG_OP_MOV, CRG_DST_ACC, 8'h05);
		ex(CRG_MODE_IMM, CRG_OP_ADD, CRG_DST_ACC, 8'hfb);
		chk(accumulator, 8'h00);
		chk(processor_flags[2], 1);
		chk(processor_flags[1], 1);
		ex(CRG_MODE_IMM, CRG_OP_MOV, CRG_DST_IDX, 8'h08);
		ex(CRG_MODE_IMM, CRG_OP_ADD, CRG_DST_IDX, 8'h01);
		chk(index, 8'h09);
		chk(processor_flags[2:1], 0);
		ex(CRG_MODE_DIRECT, CRG_OP_MOV, CRG_DST_ACC, 8'h07);
		chk({accumulator, src_addr}, 16'h5d07);
		$display("data path test done");
		ex(CRG_MODE_IMM, CRG_OP_OR, CRG_DST_FLAGS, 8'hff);
		chk(processor_flags, FLG_USER_MASK);
		chk({interrupt_master_enable, bank_select}, 2'b11);
		rd(FLAGS_ADDR);
		chk({flags_rd_hit, flags_rd_data}, {1'b1, FLG_USER_MASK});
		rd(8'hf6);
		chk({flags_rd_hit, flags_rd_data}, 0);
		exec_supervisor = 1;
		ex(CRG_MODE_IMM, CRG_OP_AND, CRG_DST_FLAGS, 8'h00);
		chk(processor_flags, 8'h08);
		exec_supervisor = 0;
		$display("flags test done");
		stk(CRG_SP_PUSH);
		stk(CRG_SP_PUSH);
		stk(CRG_SP_POP);
		chk(stack_top_pointer, 8'h01);
		ex(CRG_MODE_IMM, CRG_OP_MOV, CRG_DST_SP, 8'h40);
		chk(stack_top_pointer, 8'h40);
		{pc_load, pc_target} = {1'b1, 16'h1ffe};
		@(negedge sys_clk);
		{pc_load, pc_advance} = 2'b01;
		@(negedge sys_clk);
		pc_advance = 0;
		chk({program_counter_high, program_counter_low}, 16'h1fff);
		$display("stack and pc test done");
		ex(CRG_MODE_IMM, CRG_OP_MOV, CRG_DST_ACC, 8'h03);
		ex(CRG_MODE_IMM, CRG_OP_SUB, CRG_DST_ACC, 8'h05);
		chk({accumulator, processor_flags[2:1]}, {8'hfe, 2'b10});
		ex(CRG_MODE_IMM, CRG_OP_XOR, CRG_DST_ACC, 8'hfe);
		chk({accumulator, processor_flags[2:1]}, {8'h00, 2'b01});
		sp_data = 8'h10;
		stk(CRG_SP_CALL);
		sp_data = 8'h00;
		stk(CRG_SP_CALL);
		stk(CRG_SP_RET);
		chk(stack_top_pointer, 8'h50);
		@(negedge sys_clk);
		{exec_valid, pc_advance} = 2'b11;
		exec_dst = CRG_DST_NONE;
		@(negedge sys_clk);
		{exec_valid, pc_advance} = 2'b00;
		chk({program_counter_high, program_counter_low}, 16'h2001);
		rst_n = 0;
		@(negedge sys_clk);
		rst_n = 1;
		chk({processor_flags, stack_top_pointer, program_counter_high}, {FLG_RESET, 16'h0000});
		ex(CRG_MODE_IMM, CRG_OP_ADD, CRG_DST_ACC, 8'h07);
		chk(accumulator, 8'h07);
		$display("extended test done");
		final_report();
	end
	initial begin
		#20000;
		n_errors++;
		final_report();
	end
endmodule
`default_nettype wire
